// ===== pkg/pcs_pkg.sv
`default_nettype none

package pcs_pkg;

    // Register addresses
    localparam logic [7:0] PLL_AND_ADC_CLOCK_CONFIG_ADDR = 8'h04;
    localparam logic [7:0] CLOCK_OUTPUT_CONFIG_ADDR      = 8'h06;
    localparam logic [7:0] RX_CONVERTER_CONTROL_ADDR     = 8'h07;
    localparam logic [7:0] CONVERTER_BIAS_ADJUST_ADDR    = 8'h13;

    // Reset values
    localparam logic [7:0] PLL_AND_ADC_CLOCK_CONFIG_RST  = 8'h00;
    localparam logic [7:0] CLOCK_OUTPUT_CONFIG_RST       = 8'h00;
    localparam logic [7:0] RX_CONVERTER_CONTROL_RST      = 8'h00;
    localparam logic [7:0] CONVERTER_BIAS_ADJUST_RST     = 8'h00;

    // Field positions in pll_and_adc_clock_config
    localparam int MULT_LSB        = 0;
    localparam int RXDIV_LSB       = 2;
    localparam int RXSEL_BIT       = 4;
    localparam int DUTY_BIT        = 5;
    // Field positions in clock_output_config
    localparam int OUT1_DIS_BIT    = 0;
    localparam int OUT1_INV_BIT    = 1;
    localparam int OUT1_DIV_LSB    = 2;
    localparam int OUT2_DIS_BIT    = 4;
    localparam int OUT2_INV_BIT    = 5;
    localparam int OUT2_DIV_LSB    = 6;
    // Field positions in rx_converter_control and converter_bias_adjust
    localparam int LOWPWR_BIT      = 4;
    localparam int BIAS_LSB        = 0;

    // Receive latency in half converter clock cycles
    localparam logic [4:0] LAT_HALF_DUPLEX_HALVES = 5'h14;
    localparam logic [4:0] LAT_FULL_DUPLEX_HALVES = 5'h15;

    // Largest divide exponents of the second output and of the receive clock
    localparam logic [1:0] OUT2_DIV_MAX   = 2'h2;
    localparam logic [1:0] RXDIV_MAX      = 2'h2;

    localparam int CHAIN_W = 5;

endpackage

`default_nettype wire

// ===== rtl/pcs_clock_synth.sv
// Operation
// - Update clock is chain bit 0, half the mclk rate; M field is not used
// - Select bit picks reference or divided multiplier
// - Multiplier divided by 2^N for receive clock, N of 3 taken as 2
// - First output is multiplier over 2^R
// - First output shares the multiplier divider chain
// - Second output is reference over 2^L for L up to 2; L of 3 holds it
// - L zero passes reference, L one and two give half duty
// - Each output has invert and disable bits
// - Clock outputs keep running through reset
// - Duty-cycle restore enable bit provided
// - Low-power bit selects reduced-current converter mode
// - Three-bit receive converter bias select
// - Receive latency 10.0 or 10.5 cycles
`timescale 1ns/1ps
`default_nettype none

module pcs_clock_synth (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       ref_osc_input,
    input  wire logic       full_duplex,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_we,
    output logic      [7:0] reg_rdata,
    output logic            tx_update_clk,
    output logic            rx_word_clock,
    output logic            vco_derived_clock_out,
    output logic            ref_derived_clock_out,
    output logic            duty_restore_en,
    output logic            rx_low_power,
    output logic      [2:0] rx_bias_sel,
    output logic      [4:0] rx_latency_halves
);

    typedef struct packed {
        logic [7:0]                  pll_cfg;
        logic [7:0]                  out_cfg;
        logic [7:0]                  rx_ctl;
        logic [7:0]                  bias;
        logic [7:0]                  rdata;
        logic [pcs_pkg::CHAIN_W-1:0] chain;
        logic [3:0]                  out1_act;
        logic [3:0]                  out2_act;
        logic [1:0]                  ref_cnt;
        logic                        ref_q;
        logic                        ref_half;
        logic                        rx_clk;
        logic                        out1;
        logic                        out2;
    } pcs_state_s;

    pcs_state_s st_reg = '0;
    pcs_state_s st_next;

    // Picks bit 2^e of the divider chain as a clock level
    function automatic logic chain_tap(input logic [pcs_pkg::CHAIN_W-1:0] c,
                                       input logic [2:0] e);
        chain_tap = c[e];
    endfunction

    // Divider chain lower bits all zero: a safe point to change settings
    function automatic logic chain_wrap(input logic [pcs_pkg::CHAIN_W-1:0] c,
                                        input logic [2:0] e);
        logic [pcs_pkg::CHAIN_W-1:0] m;
        m = (5'h01 << e) - 5'h01;
        chain_wrap = ((c & m) == 5'h00) && !c[e];
    endfunction

    // Widens a two-bit divide exponent to a chain tap index
    function automatic logic [2:0] tap_idx(input logic [1:0] d);
        tap_idx = {1'b0, d};
    endfunction

    // Larger of two divide exponents
    function automatic logic [1:0] exp_max(input logic [1:0] a,
                                           input logic [1:0] b);
        exp_max = (a > b) ? a : b;
    endfunction

    // Output pin level: held at the invert level while disabled
    function automatic logic pin_level(input logic dis,
                                       input logic inv,
                                       input logic clk);
        if (dis) begin
            pin_level = inv;
        end else begin
            pin_level = clk ^ inv;
        end
    endfunction

    // Read data multiplexer; unmapped addresses read as zero
    function automatic logic [7:0] reg_read(input logic [7:0] a,
                                            input logic [7:0] pll,
                                            input logic [7:0] outc,
                                            input logic [7:0] rxc,
                                            input logic [7:0] bias);
        case (a)
            pcs_pkg::PLL_AND_ADC_CLOCK_CONFIG_ADDR: reg_read = pll;
            pcs_pkg::CLOCK_OUTPUT_CONFIG_ADDR:      reg_read = outc;
            pcs_pkg::RX_CONVERTER_CONTROL_ADDR:     reg_read = rxc;
            pcs_pkg::CONVERTER_BIAS_ADJUST_ADDR:    reg_read = bias;
            default:                                reg_read = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [1:0] rxdiv;
    logic [1:0] d1;
    logic [1:0] d1_new;
    logic [1:0] d2;
    logic       ref_rise;

    always_comb begin
        st_next  = st_reg;
        rxdiv    = st_reg.pll_cfg[pcs_pkg::RXDIV_LSB +: 2];
        d1       = st_reg.out1_act[3:2];
        d1_new   = st_reg.out_cfg[pcs_pkg::OUT1_DIV_LSB +: 2];
        d2       = st_reg.out2_act[3:2];
        ref_rise = ref_osc_input && !st_reg.ref_q;

        // Chain free-runs at mclk rate, reset never touches it
        st_next.chain = st_reg.chain + 5'h01;
        st_next.ref_q = ref_osc_input;

        // Receive clock: buffered reference or chain tap 2^N
        if (st_reg.pll_cfg[pcs_pkg::RXSEL_BIT]) begin
            case (rxdiv)
                2'h0, 2'h1, 2'h2: begin
                    st_next.rx_clk = chain_tap(st_reg.chain, tap_idx(rxdiv));
                end
                default: begin
                    st_next.rx_clk = chain_tap(st_reg.chain, 3'(pcs_pkg::RXDIV_MAX));
                end
            endcase
        end else begin
            st_next.rx_clk = ref_osc_input;
        end

        // New settings start where both old and new taps begin a full low phase
        if (chain_wrap(st_reg.chain, tap_idx(exp_max(d1, d1_new)))) begin
            st_next.out1_act = st_reg.out_cfg[pcs_pkg::OUT1_DIS_BIT +: 4];
        end
        st_next.out1 = pin_level(st_reg.out1_act[pcs_pkg::OUT1_DIS_BIT],
                                 st_reg.out1_act[pcs_pkg::OUT1_INV_BIT],
                                 chain_tap(st_reg.chain, tap_idx(d1)));

        // Second output divides reference rising edges
        if (ref_rise) begin
            st_next.ref_cnt = st_reg.ref_cnt + 2'h1;
            case (d2)
                2'h1: begin
                    st_next.ref_half = !st_reg.ref_half;
                end
                pcs_pkg::OUT2_DIV_MAX: begin
                    if (st_reg.ref_cnt[0]) begin
                        st_next.ref_half = !st_reg.ref_half;
                    end
                end
                default: begin
                    st_next.ref_half = st_reg.ref_half;
                end
            endcase
        end

        // Second output settings change only while the pin sits at its invert level
        if (st_reg.out2 == st_reg.out2_act[1]) begin
            st_next.out2_act = st_reg.out_cfg[pcs_pkg::OUT2_DIS_BIT +: 4];
        end
        if (d2 == 2'h0) begin
            st_next.out2 = pin_level(st_reg.out2_act[0],
                                     st_reg.out2_act[1],
                                     ref_osc_input);
        end else begin
            st_next.out2 = pin_level(st_reg.out2_act[0],
                                     st_reg.out2_act[1],
                                     st_reg.ref_half);
        end

        // Register port
        st_next.rdata = reg_read(reg_addr, st_reg.pll_cfg, st_reg.out_cfg,
                                 st_reg.rx_ctl, st_reg.bias);
        if (reg_we) begin
            case (reg_addr)
                pcs_pkg::PLL_AND_ADC_CLOCK_CONFIG_ADDR: st_next.pll_cfg = reg_wdata;
                pcs_pkg::CLOCK_OUTPUT_CONFIG_ADDR:      st_next.out_cfg = reg_wdata;
                pcs_pkg::RX_CONVERTER_CONTROL_ADDR:     st_next.rx_ctl  = reg_wdata;
                pcs_pkg::CONVERTER_BIAS_ADJUST_ADDR:    st_next.bias    = reg_wdata;
                default: ;
            endcase
        end

        // Reset restores configuration and clears read data; clocks keep running
        if (rst) begin
            st_next.pll_cfg = pcs_pkg::PLL_AND_ADC_CLOCK_CONFIG_RST;
            st_next.out_cfg = pcs_pkg::CLOCK_OUTPUT_CONFIG_RST;
            st_next.rx_ctl  = pcs_pkg::RX_CONVERTER_CONTROL_RST;
            st_next.bias    = pcs_pkg::CONVERTER_BIAS_ADJUST_RST;
            st_next.rdata   = 8'h00;
        end
    end

    always_ff @(posedge mclk) begin
        st_reg <= st_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Update clock: chain bit 0 is the oscillator, independent of the reference and M
    assign tx_update_clk         = st_reg.chain[0];
    assign rx_word_clock         = st_reg.rx_clk;
    assign vco_derived_clock_out = st_reg.out1;
    assign ref_derived_clock_out = st_reg.out2;
    assign reg_rdata             = st_reg.rdata;
    assign duty_restore_en       = st_reg.pll_cfg[pcs_pkg::DUTY_BIT];
    assign rx_low_power          = st_reg.rx_ctl[pcs_pkg::LOWPWR_BIT];
    assign rx_bias_sel           = st_reg.bias[pcs_pkg::BIAS_LSB +: 3];
    assign rx_latency_halves     = full_duplex ? pcs_pkg::LAT_FULL_DUPLEX_HALVES
                                               : pcs_pkg::LAT_HALF_DUPLEX_HALVES;

endmodule

`default_nettype wire

// ===== tb/pcs_clock_synth_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pcs_chk (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       ref_osc_input,
    input wire logic       full_duplex,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_we,
    input wire logic [7:0] reg_rdata,
    input wire logic       tx_update_clk,
    input wire logic       rx_word_clock,
    input wire logic       vco_derived_clock_out,
    input wire logic       ref_derived_clock_out,
    input wire logic       duty_restore_en,
    input wire logic       rx_low_power,
    input wire logic [2:0] rx_bias_sel,
    input wire logic [4:0] rx_latency_halves
);
    logic [7:0] c4;
    logic [7:0] c6;
    logic [5:0] age;
    // Mirror of the two clock registers; age counts cycles since output config changed
    always_ff @(posedge mclk) begin
        if (rst) begin
            c4 <= 8'h00;
            c6 <= 8'h00;
            age <= 6'h00;
        end else begin
            if (reg_we && reg_addr == 8'h04) c4 <= reg_wdata;
            if (reg_we && reg_addr == 8'h06) c6 <= reg_wdata;
            if (reg_we && reg_addr == 8'h06) age <= 6'h00;
            else if (age != 6'h3F) age <= age + 6'h01;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_lat; rx_latency_halves == (full_duplex ? 5'h15 : 5'h14); endproperty
    property p_tx; 1'b1 |=> tx_update_clk != $past(tx_update_clk); endproperty
    property p_rd; reg_we && reg_addr == 8'h13 ##1 reg_addr == 8'h13 && !reg_we
        |=> reg_rdata == $past(reg_wdata, 2); endproperty
    property p_bias; reg_we && reg_addr == 8'h13 |=> rx_bias_sel == $past(reg_wdata[2:0]);
    endproperty
    property p_lp; reg_we && reg_addr == 8'h07 |=> rx_low_power == $past(reg_wdata[4]);
    endproperty
    property p_duty; reg_we && reg_addr == 8'h04 |=> duty_restore_en == $past(reg_wdata[5]);
    endproperty
    property p_rxref; !c4[4] |=> rx_word_clock == $past(ref_osc_input); endproperty
    property p_o2; age > 6'd40 && c6[7:6] == 2'h0 && !c6[4]
        |=> ref_derived_clock_out == ($past(ref_osc_input) ^ $past(c6[5])); endproperty
    property p_d1; age > 6'd40 && c6[0] |-> vco_derived_clock_out == c6[1]; endproperty
    property p_d2; age > 6'd40 && c6[4] |-> ref_derived_clock_out == c6[5]; endproperty
    property p_div1; age > 6'd40 && c6[3:2] == 2'h0 && !c6[0]
        |=> vco_derived_clock_out != $past(vco_derived_clock_out); endproperty
    a_lat: assert property (p_lat) else $error("latency figure wrong");
    a_tx: assert property (p_tx) else $error("update clock stalled");
    a_rd: assert property (p_rd) else $error("readback wrong");
    a_bias: assert property (p_bias) else $error("bias select wrong");
    a_lp: assert property (p_lp) else $error("low power bit wrong");
    a_duty: assert property (p_duty) else $error("duty restore bit wrong");
    a_rxref: assert property (p_rxref) else $error("rx clock not reference");
    a_o2: assert property (p_o2) else $error("output two passthrough wrong");
    a_d1: assert property (p_d1) else $error("output one not static");
    a_d2: assert property (p_d2) else $error("output two not static");
    a_div1: assert property (p_div1) else $error("output one not toggling");
    c_rxpll: cover property (c4[4] && rx_word_clock);
    c_dis: cover property (age > 6'd40 && c6[0] && c6[4]);
    c_bias: cover property (reg_we && reg_addr == 8'h13);
endmodule
bind pcs_clock_synth pcs_chk u_chk (.*);
`default_nettype wire

// ===== tb/pcs_ref_osc.sv
`timescale 1ns/1ps
`default_nettype none
module pcs_ref_osc (
    input wire logic       mclk,
    input wire logic [1:0] half_m1,
    output logic           ref_osc_input
);
    logic [1:0] cnt = 2'h0;
    initial ref_osc_input = 1'b0;
    // Free-running reference, half period of half_m1+1 cycles
    always @(negedge mclk) begin
        if (cnt >= half_m1) begin
            cnt = 2'h0;
            ref_osc_input = ~ref_osc_input;
        end else begin
            cnt = cnt + 2'h1;
        end
    end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic mclk = 1'b0, rst = 1'b1, full_duplex = 1'b0, reg_we = 1'b0, refc, o_dr, o_lp;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata;
    logic [1:0] half_m1 = 2'h0;
    logic [3:0] outs;
    logic [2:0] bias;
    logic [4:0] lat;
    int failures = 0, samples_checked = 0, i;
    always #50 mclk = ~mclk;
    pcs_ref_osc u_ref (.mclk(mclk), .half_m1(half_m1), .ref_osc_input(refc));
    pcs_clock_synth u_dut (.mclk(mclk), .rst(rst), .ref_osc_input(refc),
        .full_duplex(full_duplex), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_rdata(rdata), .tx_update_clk(outs[0]),
        .rx_word_clock(outs[1]), .vco_derived_clock_out(outs[2]),
        .ref_derived_clock_out(outs[3]), .duty_restore_en(o_dr),
        .rx_low_power(o_lp), .rx_bias_sel(bias), .rx_latency_halves(lat));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_we = 1'b1;
        @(negedge mclk);
        reg_we = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk);
        reg_addr = a;
        @(negedge mclk);
        chk(rdata, exp);
    endtask
    // Counts output toggles over n cycles after a settle time
    task automatic tog(input int s, input int n, input int exp);
        logic p;
        int c;
        c = 0;
        repeat (40) @(negedge mclk);
        p = outs[s];
        repeat (n) begin
            @(negedge mclk);
            if (outs[s] !== p) c++;
            p = outs[s];
        end
        chk(c[7:0], exp[7:0]);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        rd(8'h04, 8'h00);
        rd(8'h06, 8'h00);
        rd(8'h07, 8'h00);
        rd(8'h13, 8'h00);
        wr(8'h13, 8'hA5);
        rd(8'h13, 8'hA5);
        chk({5'h00, bias}, 8'h05);
        wr(8'h07, 8'h10);
        chk({7'h00, o_lp}, 8'h01);
        wr(8'h04, 8'h20);
        chk({7'h00, o_dr}, 8'h01);
        wr(8'h05, 8'hFF);
        rd(8'h05, 8'h00);
        chk({3'h0, lat}, 8'h14);
        full_duplex = 1'b1;
        #1 chk({3'h0, lat}, 8'h15);
        $display("registers done");
        for (i = 0; i < 3; i++) begin
            wr(8'h04, 8'h10 | 8'(i << 2));
            tog(1, 32, 32 >> i);
        end
        half_m1 = 2'h1;
        wr(8'h04, 8'h00);
        tog(1, 32, 16);
        tog(0, 32, 32);
        half_m1 = 2'h0;
        for (i = 0; i < 4; i++) begin
            wr(8'h06, 8'(i << 2));
            tog(2, 32, 32 >> i);
        end
        wr(8'h06, 8'h03);
        tog(2, 32, 0);
        chk({7'h00, outs[2]}, 8'h01);
        for (i = 0; i < 3; i++) begin
            wr(8'h06, 8'(i << 6));
            tog(3, 32, 32 >> i);
        end
        wr(8'h06, 8'h30);
        tog(3, 32, 0);
        chk({7'h00, outs[3]}, 8'h01);
        $display("clock outputs done");
        rst = 1'b1;
        tog(0, 16, 16);
        tog(2, 16, 16);
        rst = 1'b0;
        rd(8'h13, 8'h00);
        $display("reset run done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
